// [src/dram_ctrl_access_inputs.sv]
// Access front end of a programmable DRAM controller with two host ports.
// Assumes synchronous inputs, external address multiplexing for port B
// and an outside refresh timer that supplies requests and row addresses.
//
// Behaviour
// RULE1: Pipelining holds column address, then muxes row address onto outputs.
// RULE2: Second port served with request, acknowledge, lock and grant.
// RULE3: Port A, port B and refresh arbitrated; loser gets wait states.
// RULE4: Outside logic muxes port addresses onto one bus, steered by grant.
// RULE5: Active-low asserted at logic 0, active-high asserted at 1.
// RULE6: Row inputs give DRAM row; program bits except bit 10.
// RULE7: Column inputs give DRAM column; program bits except bit 10.
// RULE8: Bank selects choose strobe group per configuration; also program. prog_register decodes nothing from bankBits.
// RULE9: Column strobes set by CAS enables, bank selects and configuration.
// RULE10: Toggling CAS enables toggles strobes for page and byte writes.
// RULE11: With extension set, CAS enable 0 keeps CAS after RAS negates.
// RULE12: Scrubbing refreshes ignore all CAS enables.
// RULE13: Write strobe follows write request when CAS enable 0 programmed. With pipelining set it gives the refresh request instead.
// RULE14: Column bit 9 set delays CAS one clock on writes.
// RULE15: Write strobe means write/read, else refresh request output.
// RULE16: Programming register captures while mode load is low.
// RULE17: Address outputs show row, column, or refresh address.
// RULE18: Configuration holds after programming until reprogram or reset.
`timescale 1ns/1ps
module dram_ctrl_access_inputs
    import dram_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Address and programming inputs
    input  wire logic              progLoad_n,
    input  wire logic [ADDR_W-1:0] rowAddrIn,
    input  wire logic [ADDR_W-1:0] colAddrIn,
    input  wire logic [1:0]        bankSel,
    input  wire logic [BANKS-1:0]  casEnable_n,
    input  wire logic              writeReq_n,
    // Port A
    input  wire logic              portAAccessReq_n,
    output logic                   portAWait_n,
    // Port B
    input  wire logic              portBAccessReq_n,
    input  wire logic              lock_n,
    output logic                   portBAck_n,
    output logic                   portBGrant_n,
    // Refresh
    input  wire logic              refreshPending,
    input  wire logic              refreshScrub,
    input  wire logic [ADDR_W-1:0] refreshAddr,
    output logic                   refreshInProgress_n,
    // DRAM side
    output logic [ADDR_W-1:0]      dramAddrOut,
    output logic [BANKS-1:0]       rasOut_n,
    output logic [BANKS-1:0]       casOut_n,
    output logic                   writeStrobe_n
);

    // Assertion clock and reset for the checks below
    default clocking assertClk @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ========================================================
    // Programming path
    prog_bus_if prog ();
    cfg_t       cfg;

    // Active-low pins turned into asserted levels
    wire port_a_access_req    = ~portAAccessReq_n;                     // RULE5
    wire bReq    = ~portBAccessReq_n;                     // RULE5
    wire writeOn = ~writeReq_n;                           // RULE5
    wire [BANKS-1:0] casOn = ~casEnable_n;                // RULE5

    // Programming bits, top address bit (bit 10) left out
    assign prog.load            = ~progLoad_n;            // RULE16
    assign prog.rowBits         = rowAddrIn[PROG_W-1:0];  // RULE6
    assign prog.colBits         = colAddrIn[PROG_W-1:0];  // RULE7
    assign prog.bankBits        = bankSel;                // RULE8
    assign prog.casBit0Asserted = casOn[0];
    assign cfg                  = prog.cfg;

    prog_register progStore (
        .clk     (clk),
        .reset_n (reset_n),
        .prog    (prog.store)
    );

    // ========================================================
    // Sequencer state
    typedef enum logic [2:0] {
        IDLE, ROW, CAS_WAIT, COL, PIPE, CAS_EXT, REFRESH
    } state_t;

    state_t             state;
    state_t             next_state;
    owner_t             owner;
    owner_t             next_owner;
    logic               lastB;
    logic [CNT_W-1:0]   count;
    logic [CNT_W-1:0]   next_count;

    // ========================================================
    // Arbitration among the ports and refresh
    wire lockToB  = ~lock_n & lastB;
    wire pickRfsh = refreshPending;                        // RULE3
    wire pickA    = ~pickRfsh & port_a_access_req & ~(lockToB & bReq);  // RULE3
    wire pickB    = ~pickRfsh & ~pickA & bReq;             // RULE2
    wire ownReq   = (owner == OWN_A) ? port_a_access_req :
                    (owner == OWN_B) ? bReq : 1'b0;
    wire colPhase = (state == COL) || (state == PIPE) ||
                    (state == CAS_EXT);
    wire holdDone = count >= CNT_W'(COL_HOLD_CYC);
    wire rfshDone = count >= CNT_W'(RFSH_LOW_CYC - 1);

    // Next state and owner
    always_comb begin
        next_state = state;
        next_owner = owner;
        next_count = count;
        case (state)
            IDLE: begin
                next_count = '0;
                if (pickRfsh) begin
                    next_state = REFRESH;
                    next_owner = OWN_RFSH;
                end else if (pickA) begin
                    next_state = ROW;
                    next_owner = OWN_A;
                end else if (pickB) begin
                    next_state = ROW;
                    next_owner = OWN_B;
                end
            end
            ROW: begin
                if (cfg.delayCasWrite && writeOn) begin
                    next_state = CAS_WAIT;                 // RULE14
                end else begin
                    next_state = COL;
                end
            end
            CAS_WAIT: next_state = COL;                    // RULE14
            COL, PIPE: begin
                next_count = holdDone ? count : count + 1'b1;
                if (!ownReq) begin
                    next_state = (cfg.casExtend && casOn[0]) ?
                                 CAS_EXT : IDLE;           // RULE11
                    next_owner = OWN_NONE;
                end else if (cfg.pipeline && holdDone) begin
                    next_state = PIPE;                     // RULE1
                end
            end
            CAS_EXT: begin
                if (!casOn[0]) begin
                    next_state = IDLE;                     // RULE11
                end
            end
            REFRESH: begin
                next_count = count + 1'b1;
                if (rfshDone) begin
                    next_state = IDLE;
                    next_owner = OWN_NONE;
                end
            end
            default: begin
                next_state = IDLE;
                next_owner = OWN_NONE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= IDLE;
            owner <= OWN_NONE;
            count <= '0;
            lastB <= 1'b0;
        end else begin
            state <= next_state;
            owner <= next_owner;
            count <= next_count;
            if (next_owner == OWN_A || next_owner == OWN_B) begin
                lastB <= (next_owner == OWN_B);
            end
        end
    end

    // ========================================================
    // Strobe group selection by bank mode
    wire [BANKS-1:0] bankOneHot = ONE_HOT << bankSel;
    wire [BANKS-1:0] rasMask =
        (cfg.bankMode == BMODE_ONE) ? MASK_ALL :
        (cfg.bankMode == BMODE_TWO) ?
            (bankSel[0] ? MASK_HIGH : MASK_LOW) :
        bankOneHot;                                        // RULE8
    // Byte lanes in shared modes, one strobe per bank otherwise
    wire [BANKS-1:0] casMask =
        (cfg.bankMode == BMODE_ONE || cfg.bankMode == BMODE_TWO) ?
            (casOn & rasMask) :
            (rasMask & {BANKS{|casOn}});                   // RULE9

    // ========================================================
    // Next DRAM outputs
    logic [ADDR_W-1:0] next_addr;
    logic [BANKS-1:0]  next_ras;
    logic [BANKS-1:0]  next_cas;
    logic [BANKS-1:0]  bankRas;

    always_comb begin
        next_addr = rowAddrIn;
        next_ras  = MASK_NONE;
        next_cas  = MASK_NONE;
        case (next_state)
            ROW, CAS_WAIT: begin
                next_addr = rowAddrIn;                     // RULE17
                next_ras  = rasMask;
            end
            COL: begin
                next_addr = colAddrIn;                     // RULE17
                next_ras  = rasMask;
                next_cas  = casMask;                       // RULE10
            end
            PIPE: begin
                next_addr = rowAddrIn;                     // RULE1
                next_ras  = bankRas | rasMask;
                next_cas  = casMask;
            end
            CAS_EXT: begin
                next_addr = dramAddrOut;                   // Column, or row after PIPE, held
                next_cas  = casMask;                       // RULE11
            end
            REFRESH: begin
                next_addr = refreshAddr;                   // RULE17
                next_ras  = MASK_ALL;
                next_cas  = refreshScrub ? MASK_ALL :
                            MASK_NONE;                     // RULE12
            end
            default: begin
                next_addr = rowAddrIn;
            end
        endcase
    end

    // Registered DRAM outputs, strobes active low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dramAddrOut <= '0;
            rasOut_n    <= MASK_ALL;
            casOut_n    <= MASK_ALL;
            bankRas     <= MASK_NONE;
        end else begin
            dramAddrOut <= next_addr;
            rasOut_n    <= ~next_ras;
            casOut_n    <= ~next_cas;
            bankRas     <= (state == COL) ? rasMask : bankRas;
        end
    end

    // ========================================================
    // Handshakes and write strobe
    logic port_b_grant;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port_b_grant <= 1'b0;
        end else begin
            port_b_grant <= (next_owner == OWN_B);               // RULE4
        end
    end

    // Grant leads the access by a cycle so the outside mux shows B's row
    assign portBGrant_n = ~(port_b_grant || (next_owner == OWN_B)); // RULE2 RULE4
    assign portBAck_n   = ~((owner == OWN_B) && colPhase); // RULE2
    assign portAWait_n  = ~(port_a_access_req && !((owner == OWN_A)
                            && colPhase));                 // RULE3
    assign refreshInProgress_n = ~(state == REFRESH);
    // Refresh request replaces write when pipelining or extending
    wire weIsRfrq = cfg.pipeline || !cfg.weFollowsWrite;   // RULE15
    assign writeStrobe_n = weIsRfrq ? ~refreshPending :
                                      writeReq_n;          // RULE13

    // ========================================================
    // Checks
    pipe_row_a: assert property ( // RULE1
        state == PIPE |-> dramAddrOut == $past(rowAddrIn))
        else $error("pipelined access did not show row address");

    lost_wait_a: assert property ( // RULE3
        port_a_access_req && owner == OWN_B |-> !portAWait_n)
        else $error("port A not held off while B owns memory");

    b_ack_a: assert property ( // RULE2
        !portBAck_n |-> !portBGrant_n)
        else $error("port B acknowledged without grant");

    cas_ext_a: assert property ( // RULE11
        state == CAS_EXT |-> &rasOut_n && cfg.casExtend)
        else $error("column extension with row strobes asserted");

    scrub_cas_a: assert property ( // RULE12
        state == REFRESH && $past(refreshScrub)
        && $past(next_state) == REFRESH |-> casOut_n == ~MASK_ALL)
        else $error("scrub refresh followed CAS enables");

    we_follow_a: assert property ( // RULE13
        !cfg.pipeline && cfg.weFollowsWrite |->
        writeStrobe_n == writeReq_n)
        else $error("write strobe did not follow write request");

    cas_delay_a: assert property ( // RULE14
        state == ROW && cfg.delayCasWrite && writeOn |=>
        state == CAS_WAIT ##1 state == COL)
        else $error("column strobe not delayed on write");

    rfsh_addr_a: assert property ( // RULE17
        state == REFRESH |-> dramAddrOut == $past(refreshAddr))
        else $error("refresh address not on outputs");

    refresh_request_out_out_a: assert property ( // RULE15
        cfg.pipeline |-> writeStrobe_n == !refreshPending)
        else $error("write strobe not refresh request");

endmodule // dram_ctrl_access_inputs

// [src/dram_ctrl_pkg.sv]
// Constants, configuration fields and types for the DRAM access front end.
// Assumes a single 250 MHz system clock.
package dram_ctrl_pkg;

    // ========================================================
    // Widths
    localparam int ADDR_W = 11;
    localparam int PROG_W = 10;
    localparam int BANKS  = 4;

    // ========================================================
    // Clock and timing
    localparam int CLK_PERIOD_PS = 4000;
    // Column address hold before the row address is switched in
    localparam int COL_HOLD_PS   = 8000;
    localparam int COL_HOLD_CYC  =
        (COL_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Row strobe low time of a refresh
    localparam int RFSH_LOW_PS   = 12000;
    localparam int RFSH_LOW_CYC  =
        (RFSH_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W         = 4;

    // ========================================================
    // Programming field positions
    localparam int ROW_PIPE_BIT   = 0;
    localparam int ROW_BMODE_LSB  = 1;
    localparam int COL_DELAY_BIT  = 9;

    // Bank modes of the strobe groups
    localparam logic [1:0] BMODE_ONE  = 2'h0;
    localparam logic [1:0] BMODE_TWO  = 2'h1;

    // Strobe masks
    localparam logic [3:0] MASK_ALL   = 4'hF;
    localparam logic [3:0] MASK_LOW   = 4'h3;
    localparam logic [3:0] MASK_HIGH  = 4'hC;
    localparam logic [3:0] MASK_NONE  = 4'h0;
    localparam logic [3:0] ONE_HOT    = 4'h1;

    // ========================================================
    // Captured configuration
    typedef struct packed {
        logic       pipeline;
        logic [1:0] bankMode;
        logic       delayCasWrite;
        logic       casExtend;
        logic       weFollowsWrite;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{
        pipeline:       1'b0,
        bankMode:       2'h0,
        delayCasWrite:  1'b0,
        casExtend:      1'b0,
        weFollowsWrite: 1'b1
    };

    typedef enum logic [1:0] {
        OWN_NONE, OWN_A, OWN_B, OWN_RFSH
    } owner_t;

endpackage

// [src/prog_bus_if.sv]
// Carries programming bits to the configuration store and the result back.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface prog_bus_if;
    import dram_ctrl_pkg::*;

    logic                load;
    logic [PROG_W-1:0]   rowBits;
    logic [PROG_W-1:0]   colBits;
    logic [1:0]          bankBits;
    logic                casBit0Asserted;
    cfg_t                cfg;

    modport source (output load, rowBits, colBits, bankBits,
                    output casBit0Asserted, input cfg);
    modport store  (input load, rowBits, colBits, bankBits,
                    input casBit0Asserted, output cfg);
endinterface // prog_bus_if

// [src/prog_register.sv]
// Configuration store loaded while the programming strobe is asserted.
// Assumes synchronous active-low reset on the system clock.
`timescale 1ns/1ps
module prog_register
    import dram_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Programming bus
    prog_bus_if.store prog
);

    // ========================================================
    // Decode of the programming bits
    cfg_t next_cfg;
    assign next_cfg.pipeline       = prog.rowBits[ROW_PIPE_BIT];
    assign next_cfg.bankMode       = prog.rowBits[ROW_BMODE_LSB +: 2];
    assign next_cfg.delayCasWrite  = prog.colBits[COL_DELAY_BIT];
    assign next_cfg.casExtend      = ~prog.casBit0Asserted;
    assign next_cfg.weFollowsWrite = prog.casBit0Asserted;

    // Capture while loading, hold otherwise
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prog.cfg <= CFG_RESET;
        end else if (prog.load) begin // RULE16
            prog.cfg <= next_cfg;
        end
    end

    // Held value after the strobe goes away
    hold_cfg_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE18
        !prog.load ##1 !prog.load |-> $stable(prog.cfg))
        else $error("configuration changed without programming");

endmodule // prog_register

// [bench/host_port_model.sv]
// Model of the two hosts that share the controller's address inputs.
// Assumes the bench pulses goA/goB on falling edges of the clock.
`timescale 1ns/1ps
module host_port_model
    import dram_ctrl_pkg::*;
(
    // Clock and commands
    input  wire logic              clk,
    input  wire logic              goA,
    input  wire logic              goB,
    input  wire logic [3:0]        holdCyc,
    // Host addresses
    input  wire logic [ADDR_W-1:0] rowA,
    input  wire logic [ADDR_W-1:0] colA,
    input  wire logic [ADDR_W-1:0] rowB,
    input  wire logic [ADDR_W-1:0] colB,
    // Controller handshake
    input  wire logic              portAWait_n,
    input  wire logic              portBAck_n,
    input  wire logic              portBGrant_n,
    output logic                   portAAccessReq_n,
    output logic                   portBAccessReq_n,
    output logic [ADDR_W-1:0]      rowAddrIn,
    output logic [ADDR_W-1:0]      colAddrIn
);
    // ==========================================================
    // Hold counters
    logic [3:0] cntA;
    logic [3:0] cntB;

    // Outside address mux, steered by the grant
    assign rowAddrIn = portBGrant_n ? rowA : rowB;
    assign colAddrIn = portBGrant_n ? colA : colB;

    initial begin
        portAAccessReq_n = 1'b1;
        portBAccessReq_n = 1'b1;
    end

    // Requests held until served, then holdCyc cycles more
    always @(negedge clk) begin
        if (goA && portAAccessReq_n) begin
            portAAccessReq_n <= 1'b0;
            cntA             <= 4'h0;
        end else if (!portAAccessReq_n && portAWait_n) begin
            portAAccessReq_n <= (cntA == holdCyc);
            cntA             <= cntA + 4'h1;
        end
        if (goB && portBAccessReq_n) begin
            portBAccessReq_n <= 1'b0;
            cntB             <= 4'h0;
        end else if (!portBAccessReq_n && !portBAck_n) begin
            portBAccessReq_n <= (cntB == holdCyc);
            cntB             <= cntB + 4'h1;
        end
    end
endmodule // host_port_model

// [bench/testbench.sv]
// Self-checking bench for the DRAM access front end.
// Assumes a 250 MHz clock and the host model on the access ports.
`timescale 1ns/1ps
module testbench;
    import dram_ctrl_pkg::*;
    // ==========================================================
    // Signals
    logic clk = 1'b0, reset_n = 1'b0, progLoad_n = 1'b1, lock_n = 1'b1;
    logic writeReq_n = 1'b1, refreshPending = 1'b0, refreshScrub = 1'b0;
    logic goA = 1'b0, goB = 1'b0;
    logic [1:0] bankSel = 2'h0, m, bs;
    logic [3:0] casEnable_n = 4'h0, holdCyc = 4'h2, en, er, ec;
    logic [ADDR_W-1:0] rowA = '0, colA = '0, rowB = '0, colB = '0;
    logic [ADDR_W-1:0] refreshAddr = '0, rowAddrIn, colAddrIn, dramAddrOut;
    logic portAAccessReq_n, portBAccessReq_n, portAWait_n, portBAck_n;
    logic portBGrant_n, refreshInProgress_n, writeStrobe_n;
    logic [BANKS-1:0] rasOut_n, casOut_n;
    int bad_count = 0, comparisons = 0, k;
    // Rows: {bank mode, bank select, enables, RAS expected, CAS expected}
    logic [15:0] rows [7] = '{16'h0000, 16'h3A0A, 16'h40CC, 16'h5437,
                              16'hA0BB, 16'hF077, 16'h92DD};

    always #2 clk = ~clk;

    dram_ctrl_access_inputs i_dram_ctrl_access_inputs (.clk, .reset_n,
        .progLoad_n, .rowAddrIn, .colAddrIn, .bankSel, .casEnable_n,
        .writeReq_n, .portAAccessReq_n, .portAWait_n, .portBAccessReq_n,
        .lock_n, .portBAck_n, .portBGrant_n, .refreshPending, .refreshScrub,
        .refreshAddr, .refreshInProgress_n, .dramAddrOut, .rasOut_n,
        .casOut_n, .writeStrobe_n);
    host_port_model i_host_port_model (.clk, .goA, .goB, .holdCyc, .rowA,
        .colA, .rowB, .colB, .portAWait_n, .portBAck_n, .portBGrant_n,
        .portAAccessReq_n, .portBAccessReq_n, .rowAddrIn, .colAddrIn);

    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [10:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Program one configuration word
    task automatic prog(input logic [10:0] r, c, input logic [3:0] e);
        @(negedge clk);
        rowA = r;
        colA = c;
        casEnable_n = e;
        progLoad_n = 1'b0;
        @(negedge clk);
        progLoad_n = 1'b1;
    endtask
    // Port A access; returns just before the taking edge
    task automatic start_a(input logic [10:0] r, c, input logic [1:0] b,
                           input logic [3:0] e, h);
        @(negedge clk);
        rowA = r;
        colA = c;
        bankSel = b;
        casEnable_n = e;
        holdCyc = h;
        goA <= 1'b1;
        @(negedge clk);
        goA <= 1'b0;
    endtask
    // Bounded wait for idle, then two spare cycles
    task automatic settle(input string name);
        k = 0;
        while ((portAAccessReq_n !== 1'b1 || portBAccessReq_n !== 1'b1 ||
                rasOut_n !== 4'hF || casOut_n !== 4'hF) && k < 40) begin
            tick(1);
            k++;
        end
        chk("idle", 11'h000, (k == 40));
        tick(2);
        $display("test %s done", name);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        give_verdict();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 7; i++) begin
            {m, bs, en, er, ec} = rows[i];
            prog({8'h00, m, 1'b0}, 11'h000, 4'h0);
            start_a(11'h4A5 + i, 11'h65A - i, bs, en, 4'h2);
            tick(1);
            chk("ras", er, rasOut_n);
            chk("row addr", 11'h4A5 + i, dramAddrOut);
            chk("wait", 11'h000, portAWait_n);
            tick(1);
            chk("cas", ec, casOut_n);
            chk("col addr", 11'h65A - i, dramAddrOut);
            settle("bank row");
        end
        // Extension programmed, kept, then cleared by a second reset
        prog(11'h000, 11'h000, 4'h1);
        @(negedge clk);
        writeReq_n = 1'b0;
        casEnable_n = 4'h0;
        tick(3);
        chk("we as refresh req", 11'h001, writeStrobe_n);
        @(negedge clk);
        reset_n = 1'b0;
        tick(2);
        chk("ras reset", 11'h00F, rasOut_n);
        chk("grant reset", 11'h001, portBGrant_n);
        @(negedge clk);
        reset_n = 1'b1;
        tick(1);
        chk("we follows", 11'h000, writeStrobe_n);
        chk("addr reset", 11'h000, dramAddrOut);
        settle("reset");
        // Delayed CAS on a write
        prog(11'h000, 11'h200, 4'h0);
        start_a(11'h123, 11'h456, 2'h0, 4'h0, 4'h2);
        tick(2);
        chk("cas delayed", 11'h00F, casOut_n);
        chk("we write", 11'h000, writeStrobe_n);
        tick(1);
        chk("cas late", 11'h000, casOut_n);
        @(negedge clk);
        writeReq_n = 1'b1;
        settle("delay cas");
        // Enables toggled in mid access
        prog(11'h000, 11'h000, 4'h0);
        start_a(11'h321, 11'h654, 2'h0, 4'h0, 4'h6);
        tick(3);
        @(negedge clk);
        casEnable_n = 4'h1;
        tick(2);
        chk("cas toggled", 11'h001, casOut_n);
        @(negedge clk);
        casEnable_n = 4'h0;
        tick(2);
        chk("cas back", 11'h000, casOut_n);
        settle("toggle");
        // CAS outlives RAS with extension
        prog(11'h000, 11'h000, 4'h1);
        start_a(11'h111, 11'h222, 2'h0, 4'h0, 4'h0);
        tick(5);
        chk("ras ended", 11'h00F, rasOut_n);
        chk("cas extended", 11'h000, casOut_n);
        @(negedge clk);
        casEnable_n = 4'hF;
        tick(2);
        chk("cas ended", 11'h00F, casOut_n);
        settle("extend");
        // Pipelining: row address returns after the column hold
        prog(11'h001, 11'h000, 4'h0);
        start_a(11'h3C3, 11'h2B2, 2'h0, 4'h0, 4'h4);
        tick(3);
        chk("pipe col", 11'h2B2, dramAddrOut);
        tick(3);
        chk("pipe row", 11'h3C3, dramAddrOut);
        chk("pipe cas", 11'h000, casOut_n);
        settle("pipeline");
        // Refresh beats port A, then a scrub refresh
        prog(11'h000, 11'h000, 4'h0);
        @(negedge clk);
        refreshAddr = 11'h5C3;
        colA = 11'h0AA;
        goA <= 1'b1;
        @(negedge clk);
        goA <= 1'b0;
        refreshPending = 1'b1;
        @(negedge clk);
        refreshPending = 1'b0;
        tick(1);
        chk("rfsh ras", 11'h000, rasOut_n);
        chk("rfsh addr", 11'h5C3, dramAddrOut);
        chk("rfsh flag", 11'h000, refreshInProgress_n);
        chk("rfsh cas", 11'h00F, casOut_n);
        chk("a waits", 11'h000, portAWait_n);
        for (k = 0; k < 20 && portAWait_n !== 1'b1; k++)
            tick(1);
        chk("a served", 11'h0AA, dramAddrOut);
        settle("refresh");
        @(negedge clk);
        refreshScrub = 1'b1;
        casEnable_n = 4'hF;
        refreshPending = 1'b1;
        @(negedge clk);
        refreshPending = 1'b0;
        tick(2);
        chk("scrub cas", 11'h000, casOut_n);
        @(negedge clk);
        refreshScrub = 1'b0;
        casEnable_n = 4'h0;
        settle("scrub");
        // Both ports at once: A first, B granted afterwards
        @(negedge clk);
        colA = 11'h0F0;
        rowB = 11'h70F;
        colB = 11'h30C;
        holdCyc = 4'h2;
        goA <= 1'b1;
        goB <= 1'b1;
        @(negedge clk);
        goA <= 1'b0;
        goB <= 1'b0;
        tick(3);
        chk("b held off", 11'h001, portBGrant_n);
        chk("a col", 11'h0F0, dramAddrOut);
        for (k = 0; k < 30 && portBGrant_n !== 1'b0; k++)
            tick(1);
        tick(1);
        chk("b row", 11'h70F, dramAddrOut);
        tick(1);
        chk("b ack", 11'h000, portBAck_n);
        chk("b col", 11'h30C, dramAddrOut);
        chk("b grant", 11'h000, portBGrant_n);
        settle("dual port");
        // Lock keeps B ahead of A after a B access
        @(negedge clk);
        lock_n = 1'b0;
        goA <= 1'b1;
        goB <= 1'b1;
        @(negedge clk);
        goA <= 1'b0;
        goB <= 1'b0;
        tick(1);
        chk("lock grant", 11'h000, portBGrant_n);
        chk("lock a waits", 11'h000, portAWait_n);
        @(negedge clk);
        lock_n = 1'b1;
        settle("lock");
        give_verdict();
    end
endmodule // testbench
